// >>> design/ebrg_bus_arbiter.sv
// External bus request and grant arbiter with emulator pin switch-over
`timescale 1ns/1ps
module ebrg_bus_arbiter (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       resetn,
    // Normal bus master pins
    input  wire logic                       bus_req_n,
    output logic                            bus_grant_n,
    output logic                            bus_grant_oe,
    output logic                            grant_hang_n,
    // Emulator pins
    input  wire logic                       emulator_enable,
    input  wire logic                       emulator_reset_n,
    input  wire logic                       emulator_bus_req_n,
    output logic                            emulator_bus_grant_n,
    // Chip reset pin and memory mode straps
    input  wire logic                       reset_pin_n,
    input  wire logic [ebrg_pkg::MODE_W-1:0] mode_pins,
    // Core side
    input  wire logic                       core_acc_active,
    input  wire logic                       core_ready,
    input  wire logic                       core_ext_need,
    input  wire logic                       go_mode,
    output logic                            core_stall,
    output logic                            core_bus_granted,
    // Memory interface drive enable
    output logic                            mem_drive_en,
    // Chip reset and latched mode
    output logic                            chip_reset,
    output logic [ebrg_pkg::MODE_W-1:0]     mem_mode
);
    import ebrg_pkg::*;

    logic [SYNC_W-1:0] pins_sync;
    logic              emu_on;
    logic              req_act;
    logic              rst_act;
    logic [MODE_W-1:0] mode_sync;

    // All pins cross into the core clock here
    ebrg_sync #(
        .WIDTH   (SYNC_W),
        .RST_VAL (PIN_RST_VAL)
    ) u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .async_in ({mode_pins, emulator_reset_n, reset_pin_n, emulator_enable,
                    emulator_bus_req_n, bus_req_n}),
        .sync_out (pins_sync)
    );

    // Emulation swaps which pins are listened to
    always_comb begin
        emu_on    = pins_sync[PIN_EMU_EN];
        req_act   = emu_on ? !pins_sync[PIN_EMU_REQ] : !pins_sync[PIN_BUS_REQ];
        rst_act   = emu_on ? !pins_sync[PIN_EMU_RST] : !pins_sync[PIN_RST];
        mode_sync = pins_sync[PIN_MODE_LSB +: MODE_W];
    end

    // Bus ownership state
    ebrg_state_e state_q;
    ebrg_state_e state_d;

    // Not reset by chip reset, so grants work during reset and boot
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            EBRG_OWN: begin
                if (req_act) begin
                    // Active access this cycle blocks the grant
                    state_d = core_acc_active ? EBRG_DRAIN : EBRG_GRANT;
                end
            end
            EBRG_DRAIN: begin
                if (!req_act) begin
                    state_d = EBRG_OWN;
                end else if (!core_acc_active) begin
                    // Gap between two accesses of one instruction is enough
                    state_d = EBRG_GRANT;
                end
            end
            EBRG_GRANT: begin
                if (!req_act) begin
                    state_d = EBRG_OWN;
                end
            end
            default: begin
                state_d = EBRG_OWN;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= EBRG_OWN;
        end else begin
            state_q <= state_d;
        end
    end

    // Pin and core outputs, all registered
    logic granted_d;
    logic stall_d;
    logic hang_d;
    logic bus_grant_n_q;
    logic bus_grant_oe_q;
    logic emu_grant_n_q;
    logic hang_n_q;
    logic stall_q;
    logic granted_q;
    logic drive_en_q;

    always_comb begin
        granted_d = (state_d == EBRG_GRANT);
        // Go mode stalls only when the bus is actually needed
        stall_d   = granted_d && (!go_mode || core_ext_need);
        hang_d    = stall_d && core_ready;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bus_grant_n_q  <= 1'b1;
            bus_grant_oe_q <= 1'b1;
            emu_grant_n_q  <= 1'b1;
            hang_n_q       <= 1'b1;
            stall_q        <= 1'b0;
            granted_q      <= 1'b0;
            drive_en_q     <= 1'b1;
        end else begin
            bus_grant_n_q  <= !(granted_d && !emu_on);
            bus_grant_oe_q <= !emu_on;
            emu_grant_n_q  <= !(granted_d && emu_on);
            hang_n_q       <= !hang_d;
            stall_q        <= stall_d;
            granted_q      <= granted_d;
            drive_en_q     <= !granted_d;
        end
    end

    assign bus_grant_n          = bus_grant_n_q;
    assign bus_grant_oe         = bus_grant_oe_q;
    assign emulator_bus_grant_n = emu_grant_n_q;
    assign grant_hang_n         = hang_n_q;
    assign core_stall           = stall_q;
    assign core_bus_granted     = granted_q;
    assign mem_drive_en         = drive_en_q;

    // Chip reset and mode latch; straps caught on release, never at async reset
    // Sync bank wakes with resets held, so the first latch sees the real straps
    logic              chip_rst_q;
    logic              chip_rst_d;
    logic [MODE_W-1:0] mode_q;
    logic [MODE_W-1:0] mode_d;

    always_comb begin
        chip_rst_d = rst_act;
        mode_d     = mode_q;
        // The reset source selected by emulation relatches the straps at its release
        if (chip_rst_q && !rst_act) begin
            mode_d = mode_sync;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            chip_rst_q <= 1'b1;
            mode_q     <= MODE_RST;
        end else begin
            chip_rst_q <= chip_rst_d;
            mode_q     <= mode_d;
        end
    end

    assign chip_reset = chip_rst_q;
    assign mem_mode   = mode_q;

    // Checks

    AST_GRANT_NEXT: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_q == EBRG_OWN && req_act && !core_acc_active)
        |=> (granted_q && !mem_drive_en && (go_mode || core_stall)))
        else $error("grant not given the cycle after an idle request");

    AST_GO_RUNS: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_d == EBRG_GRANT && go_mode && !core_ext_need) |=> !core_stall)
        else $error("core stalled in go mode without external need");

    AST_NO_GRANT_IN_ACCESS: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(granted_q) |-> !$past(core_acc_active))
        else $error("grant raised while an access was active");

    AST_DRAIN_WAITS: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_q == EBRG_DRAIN && req_act && core_acc_active)[*2] |-> !granted_q)
        else $error("grant given during a running access");

    AST_RELEASE: assert property (@(posedge core_clk) disable iff (!resetn)
        (granted_q && !req_act) |=> (!granted_q && mem_drive_en && !core_stall
                                     && bus_grant_n && emulator_bus_grant_n))
        else $error("bus not returned after request dropped");

    AST_GRANT_IN_RESET: assert property (@(posedge core_clk) disable iff (!resetn)
        (chip_reset && state_q == EBRG_OWN && req_act && !core_acc_active) |=> granted_q)
        else $error("grant not honoured during chip reset");

    AST_HANG_ONLY_GRANTED: assert property (@(posedge core_clk) disable iff (!resetn)
        !grant_hang_n |-> (granted_q && core_stall))
        else $error("grant hang without a stalling grant");

    AST_HANG_SET: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_q == EBRG_GRANT && req_act && core_ready && !go_mode) |=> !grant_hang_n)
        else $error("grant hang missing while core is blocked");

    AST_BOTH_RELEASE: assert property (@(posedge core_clk) disable iff (!resetn)
        (!grant_hang_n && !req_act) |=> (grant_hang_n && !granted_q))
        else $error("grant or hang held after release");

    AST_EMU_TRISTATE: assert property (@(posedge core_clk) disable iff (!resetn)
        emu_on |=> (!bus_grant_oe && bus_grant_n))
        else $error("normal grant driven during emulation");

    AST_EMU_GRANT_PIN: assert property (@(posedge core_clk) disable iff (!resetn)
        (emu_on && granted_d) |=> !emulator_bus_grant_n)
        else $error("emulator grant pin not asserted");

    AST_MODE_RELATCH: assert property (@(posedge core_clk) disable iff (!resetn)
        $fell(chip_reset) |-> (mem_mode == $past(mode_sync)))
        else $error("mode not relatched at reset release");

    AST_REQ_SYNCED: assert property (@(posedge core_clk) disable iff (!resetn)
        (!emulator_enable && bus_req_n)[*3] ##0 (!emu_on && state_q == EBRG_OWN)
        |=> !granted_q)
        else $error("grant from an unsynchronised request");

    // Grant in a gap, hold and drop
    AST_GAP_GRANT: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_q == EBRG_DRAIN && req_act && !core_acc_active)
        |=> (granted_q && !mem_drive_en))
        else $error("grant missing in the gap between two accesses");

    AST_GRANT_HOLDS: assert property (@(posedge core_clk) disable iff (!resetn)
        (granted_q && req_act) |=> granted_q)
        else $error("grant dropped while still requested");

    AST_GRANT_NEEDS_REQ: assert property (@(posedge core_clk) disable iff (!resetn)
        granted_q |-> $past(req_act))
        else $error("grant held without a request");

    // Drivers, stall and hang
    AST_DRIVE_MATCHES: assert property (@(posedge core_clk) disable iff (!resetn)
        mem_drive_en == !core_bus_granted)
        else $error("memory drivers on while granted");

    AST_STALL_NEEDS_GRANT: assert property (@(posedge core_clk) disable iff (!resetn)
        core_stall |-> core_bus_granted)
        else $error("stall without a grant");

    AST_GO_STALL_ON_NEED: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_d == EBRG_GRANT && go_mode && core_ext_need)
        |=> core_stall)
        else $error("go mode did not stall on external need");

    AST_HANG_NEEDS_READY: assert property (@(posedge core_clk) disable iff (!resetn)
        !grant_hang_n |-> $past(core_ready))
        else $error("grant hang while core not ready");

    // Emulation and chip reset tracking
    AST_EMU_IGNORES_NORMAL: assert property (@(posedge core_clk) disable iff (!resetn)
        (emu_on && state_q == EBRG_OWN && pins_sync[PIN_EMU_REQ])
        |=> !granted_q)
        else $error("normal request honoured during emulation");

    AST_CHIP_RST_TRACK: assert property (@(posedge core_clk) disable iff (!resetn)
        chip_reset == $past(rst_act))
        else $error("chip reset does not follow the selected reset pin");

    AST_MODE_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
        !chip_reset |=> $stable(mem_mode))
        else $error("memory mode changed outside a reset release");

    COV_IDLE_GRANT: cover property (@(posedge core_clk) disable iff (!resetn)
        state_q == EBRG_OWN ##1 state_q == EBRG_GRANT ##[1:20] state_q == EBRG_OWN);

    COV_DRAIN_GRANT: cover property (@(posedge core_clk) disable iff (!resetn)
        state_q == EBRG_DRAIN ##1 state_q == EBRG_GRANT);

    COV_GO_MODE_HANG: cover property (@(posedge core_clk) disable iff (!resetn)
        granted_q && go_mode && !core_stall ##[1:10] !grant_hang_n);

    COV_EMU_RESET: cover property (@(posedge core_clk) disable iff (!resetn)
        emu_on && $fell(chip_reset));

    COV_EMU_GRANT: cover property (@(posedge core_clk) disable iff (!resetn)
        emu_on && !emulator_bus_grant_n && !mem_drive_en);

endmodule

// >>> design/ebrg_pkg.sv
// Shared constants and types for the external bus request and grant block
package ebrg_pkg;

    // Synchroniser shape
    localparam int          SYNC_STAGES   = 2;
    localparam int          SYNC_W        = 8;

    // Bit positions inside the synchronised pin vector
    localparam int          PIN_BUS_REQ   = 0;
    localparam int          PIN_EMU_REQ   = 1;
    localparam int          PIN_EMU_EN    = 2;
    localparam int          PIN_RST       = 3;
    localparam int          PIN_EMU_RST   = 4;
    localparam int          PIN_MODE_LSB  = 5;

    // Memory mode pins
    localparam int          MODE_W        = 3;
    localparam logic [2:0]  MODE_RST      = 3'h0;

    // Pin levels at block reset: requests idle, emulation off, both resets held
    localparam logic [7:0]  PIN_RST_VAL   = 8'h03;

    // Bus ownership
    typedef enum logic [2:0] {
        EBRG_OWN   = 3'b001,
        EBRG_DRAIN = 3'b010,
        EBRG_GRANT = 3'b100
    } ebrg_state_e;

endpackage

// >>> design/ebrg_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module ebrg_sync #(
    parameter int               WIDTH   = ebrg_pkg::SYNC_W,
    parameter logic [WIDTH-1:0] RST_VAL = ebrg_pkg::PIN_RST_VAL
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             resetn,
    // Pins in, clean levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import ebrg_pkg::*;

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // First stage is read only by the second
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

// >>> sim/ebrg_master_model.sv
// Outside bus master model that drives the bus request pin
`timescale 1ns/1ps
module ebrg_master_model (
    // Clock
    input  wire logic core_clk,
    // Command from the bench, grant seen on the pin
    input  wire logic want,
    input  wire logic bus_grant_n,
    // Request pin, and granted cycles counted for the bench
    output logic       bus_req_n,
    output logic [7:0] held_cycles
);
    logic [7:0] held_q;

    // Request changes just after the edge that sets want, held as long as wanted
    assign bus_req_n = !want;

    // Counts granted cycles so the bench sees how long the grant stood
    assign held_cycles = held_q;
    initial held_q = 8'h00;
    always @(posedge core_clk) begin
        if (bus_grant_n === 1'b0) begin
            held_q <= held_q + 8'h01;
        end
    end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the external bus request and grant arbiter
`timescale 1ns/1ps
module tb_top;
    import ebrg_pkg::*;
    logic       core_clk, resetn, want, bus_req_n, bus_grant_n, bus_grant_oe;
    logic       grant_hang_n, emulator_enable, emulator_reset_n, emulator_bus_req_n;
    logic       emulator_bus_grant_n, reset_pin_n, core_acc_active, core_ready;
    logic       core_ext_need, go_mode, core_stall, core_bus_granted, mem_drive_en;
    logic       chip_reset;
    logic [2:0] mode_pins, mem_mode;
    int         fail_count, num_checks;
    logic [7:0] held_cycles;

    ebrg_bus_arbiter i_ebrg_bus_arbiter (.core_clk, .resetn, .bus_req_n, .bus_grant_n,
        .bus_grant_oe, .grant_hang_n, .emulator_enable, .emulator_reset_n,
        .emulator_bus_req_n, .emulator_bus_grant_n, .reset_pin_n, .mode_pins,
        .core_acc_active, .core_ready, .core_ext_need, .go_mode, .core_stall,
        .core_bus_granted, .mem_drive_en, .chip_reset, .mem_mode);

    ebrg_master_model i_ebrg_master_model (.core_clk, .want, .bus_grant_n, .bus_req_n,
        .held_cycles);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [3:0] st();
        return {bus_grant_n, mem_drive_en, core_stall, core_bus_granted};
    endfunction

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, msg, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic t_grant(input logic go);
        logic [7:0] held0;
        logic [7:0] span;
        @(posedge core_clk);
        held0 = held_cycles;
        go_mode <= go;
        core_ext_need <= 1'b0;
        want <= 1'b1;
        tick(2);
        chk(st(), 4'b1100, "grant before sync");
        tick(1);
        chk(st(), {2'b00, !go, 1'b1}, "grant");
        chk({3'h0, grant_hang_n}, {3'h0, go}, "hang");
        if (go) begin
            @(posedge core_clk);
            core_ext_need <= 1'b1;
            tick(1);
            chk(st(), 4'b0011, "go stall");
            chk({3'h0, grant_hang_n}, 4'h0, "go hang");
        end
        @(posedge core_clk);
        want <= 1'b0;
        tick(2);
        chk(st(), 4'b0011, "early release");
        tick(1);
        chk(st(), 4'b1100, "release");
        chk({3'h0, grant_hang_n}, 4'h1, "hang release");
        // Grant stands exactly as many cycles as the request was held
        span = held_cycles - held0;
        chk(span[3:0], go ? 4'h6 : 4'h4, "grant span");
        $display("test grant go=%0b done", go);
    endtask

    task automatic t_busy;
        @(posedge core_clk);
        go_mode <= 1'b0;
        core_ext_need <= 1'b0;
        core_acc_active <= 1'b1;
        want <= 1'b1;
        tick(6);
        chk(st(), 4'b1100, "grant in access");
        // Access ends here and core_acc_active stays low from now on
        @(posedge core_clk);
        core_acc_active <= 1'b0;
        #1;
        chk(st(), 4'b1100, "grant at last access");
        tick(2);
        chk(st(), 4'b0011, "grant in gap");
        @(posedge core_clk);
        want <= 1'b0;
        core_ready <= 1'b0;
        tick(1);
        chk({3'h0, grant_hang_n}, 4'h1, "hang without ready");
        tick(2);
        chk(st(), 4'b1100, "release after gap");
        $display("test busy done");
    endtask

    task automatic t_reset_held;
        @(posedge core_clk);
        reset_pin_n <= 1'b0;
        mode_pins <= 3'h5;
        core_ready <= 1'b1;
        tick(3);
        chk({3'h0, chip_reset}, 4'h1, "chip reset");
        // Request only once chip reset already stands
        @(posedge core_clk);
        want <= 1'b1;
        tick(3);
        chk(st(), 4'b0011, "grant in reset");
        @(posedge core_clk);
        reset_pin_n <= 1'b1;
        want <= 1'b0;
        tick(3);
        chk(st(), 4'b1100, "release in reset");
        chk({chip_reset, mem_mode}, 4'h5, "pin relatch");
        $display("test reset held done");
    endtask

    task automatic t_emul;
        @(posedge core_clk);
        emulator_enable <= 1'b1;
        mode_pins <= 3'h6;
        want <= 1'b1;
        tick(4);
        chk({bus_grant_oe, bus_grant_n, emulator_bus_grant_n, mem_drive_en}, 4'b0111,
            "normal pins ignored");
        @(posedge core_clk);
        emulator_bus_req_n <= 1'b0;
        tick(3);
        chk({bus_grant_oe, bus_grant_n, emulator_bus_grant_n, mem_drive_en}, 4'b0100,
            "emulator grant");
        @(posedge core_clk);
        emulator_bus_req_n <= 1'b1;
        emulator_reset_n <= 1'b0;
        want <= 1'b0;
        tick(3);
        chk({bus_grant_oe, emulator_bus_grant_n, mem_drive_en, chip_reset}, 4'b0111,
            "emulator reset");
        @(posedge core_clk);
        emulator_reset_n <= 1'b1;
        tick(3);
        chk({chip_reset, mem_mode}, 4'h6, "emulator relatch");
        @(posedge core_clk);
        emulator_enable <= 1'b0;
        tick(4);
        chk({3'h0, bus_grant_oe}, 4'h1, "normal grant back");
        $display("test emulation done");
    endtask

    initial begin
        fail_count = 0;
        num_checks = 0;
        resetn = 1'b0;
        want = 1'b0;
        emulator_enable = 1'b0;
        emulator_reset_n = 1'b1;
        emulator_bus_req_n = 1'b1;
        reset_pin_n = 1'b1;
        mode_pins = 3'h2;
        core_acc_active = 1'b0;
        core_ready = 1'b1;
        core_ext_need = 1'b0;
        go_mode = 1'b0;
        tick(2);
        chk(st(), 4'b1100, "reset state");
        chk({bus_grant_oe, emulator_bus_grant_n, grant_hang_n, chip_reset}, 4'hf,
            "reset pins");
        chk({1'b0, mem_mode}, 4'h0, "reset mode");
        @(posedge core_clk);
        resetn <= 1'b1;
        tick(4);
        chk({1'b0, mem_mode}, 4'h2, "straps after reset");
        t_grant(1'b0);
        t_grant(1'b1);
        t_busy();
        t_reset_held();
        t_emul();
        close_out();
    end

    // Whole run needs well under a microsecond per test
    initial begin
        #20000;
        fail_count++;
        close_out();
    end
endmodule
